// >>> pkg/pmrc_pkg.sv
// Constants, register map, states and carrier types of the power mode and reset controller.
`default_nettype none
package pmrc_pkg;

	// Register addresses on the special function register port.
	localparam logic [7:0] PMC_ADDR = 8'h87;
	localparam logic [7:0] OSC_ADDR = 8'hA1;
	localparam logic [7:0] MON_ADDR = 8'hFF;
	localparam logic [7:0] RSC_ADDR = 8'hEF;

	// Field positions.
	localparam int PMC_NAP_BIT = 0;
	localparam int PMC_HALT_BIT = 1;
	localparam int PMC_SCR_LSB = 2;
	localparam int PMC_SCR_MSB = 7;
	localparam int OSC_CMPW_BIT = 0;
	localparam int OSC_SLEEP_BIT = 5;
	localparam int MON_LVL_BIT = 5;
	localparam int MON_STAT_BIT = 6;
	localparam int MON_EN_BIT = 7;
	localparam int RSC_SRC_BIT = 1;
	localparam int RSC_MCD_BIT = 2;
	localparam int RSC_SWR_BIT = 4;

	// Reset values.
	localparam logic [5:0] SCR_RST = 6'h00;
	localparam logic MON_EN_RST = 1'b1;
	localparam logic MON_LVL_RST = 1'b0;
	localparam logic MON_SRC_RST = 1'b1;
	localparam logic MCD_EN_RST = 1'b1;
	localparam logic CMPW_RST = 1'b0;
	localparam logic [7:0] PORT_LATCH_RST = 8'hFF;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [3:0] WDT_CLK_DIV = 4'hC;
	localparam logic [7:0] RDATA_ZERO = 8'h00;

	// Synchroniser lanes and their idle values.
	localparam int SY_EXT = 0;
	localparam int SY_VLO = 1;
	localparam int SY_VHI = 2;
	localparam int SY_PM = 3;
	localparam int SY_CMP = 4;
	localparam int SY_MCD = 5;
	localparam int SY_W = 6;
	localparam logic [SY_W-1:0] SYNC_RST_VAL = 6'h01;

	// Timing.
	localparam int CLK_PERIOD_NS = 50;
	localparam int POR_DELAY_US = 100;
	localparam int OSC_STAB_NS = 2000;
	localparam int POR_DELAY_CYC_DEF = (POR_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OSC_STAB_CYC_DEF = (OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;

	typedef enum logic [5:0] {
		ST_RESET = 6'h01,
		ST_RUN = 6'h02,
		ST_NAP = 6'h04,
		ST_HALT = 6'h08,
		ST_SLEEP = 6'h10,
		ST_WAKE = 6'h20
	} pmrc_state_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pmrc_sfr_s;

	typedef struct packed {
		logic cpu;
		logic periph;
		logic hfosc;
		logic port_match;
	} pmrc_clk_s;

endpackage
`default_nettype wire

// >>> verif/test_pmrc_top.sv
// Self-checking testbench of the power mode and reset controller.
`timescale 1ns/100ps
`default_nettype none
module test_pmrc_top import pmrc_pkg::*;;
	localparam int POR_CYC = 8;
	localparam int STAB_CYC = 10;
	logic ref_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic ext_rst_b_in = 1'b1;
	logic vdd_ok_low_in = 1'b0;
	logic vdd_ok_high_in = 1'b0;
	logic port_match_in = 1'b0;
	logic cmp_low_in = 1'b0;
	logic clock_loss_in = 1'b0;
	pmrc_sfr_s sfr_in = '0;
	logic instr_done_in = 1'b0;
	logic irq_in = 1'b0;
	logic flash_op_in = 1'b0;
	logic [7:0] sfr_rdata_out;
	pmrc_clk_s clk_en_out;
	logic core_rst_out, port_force_out, pullup_en_out, rst_pin_out, rst_pin_oe_out;
	logic wdt_en_out, pc_load_out, wake_irq_out;
	logic [7:0] port_latch_out;
	logic [3:0] wdt_div_out;
	logic [15:0] pc_vector_out;
	int bad_count = 0;
	int compares = 0;
	int n;
	logic [7:0] rd;

	pmrc_top #(.POR_DELAY_CYC(POR_CYC), .OSC_STAB_CYC(STAB_CYC)) uut (
		.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .ext_rst_b_in(ext_rst_b_in),
		.vdd_ok_low_in(vdd_ok_low_in), .vdd_ok_high_in(vdd_ok_high_in),
		.port_match_in(port_match_in), .cmp_low_in(cmp_low_in), .clock_loss_in(clock_loss_in),
		.sfr_in(sfr_in), .instr_done_in(instr_done_in), .irq_in(irq_in),
		.flash_op_in(flash_op_in), .sfr_rdata_out(sfr_rdata_out), .clk_en_out(clk_en_out),
		.core_rst_out(core_rst_out), .port_force_out(port_force_out),
		.port_latch_out(port_latch_out), .pullup_en_out(pullup_en_out),
		.rst_pin_out(rst_pin_out), .rst_pin_oe_out(rst_pin_oe_out), .wdt_en_out(wdt_en_out),
		.wdt_div_out(wdt_div_out), .pc_load_out(pc_load_out), .pc_vector_out(pc_vector_out),
		.wake_irq_out(wake_irq_out)
	);

	always #25 ref_clk_in = ~ref_clk_in;

	task automatic end_sim();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Writes are strobed for exactly one edge; done marks the writing instruction complete.
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d, input logic done);
		@(posedge ref_clk_in);
		sfr_in <= '{1'b1, 1'b0, a, d};
		instr_done_in <= done;
		@(posedge ref_clk_in);
		sfr_in <= '0;
		instr_done_in <= 1'b0;
	endtask

	task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_in);
		sfr_in <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge ref_clk_in);
		sfr_in <= '0;
		@(negedge ref_clk_in);
		d = sfr_rdata_out;
	endtask

	function automatic logic pick(input int sel);
		case (sel)
			0: return core_rst_out;
			1: return wake_irq_out;
			2: return clk_en_out.hfosc;
			default: return clk_en_out.cpu;
		endcase
	endfunction

	// Counts falling edges up to and including the one where the signal shows the value.
	task automatic wait_sig(input int sel, input logic val, output int cnt);
		cnt = 0;
		do begin
			@(negedge ref_clk_in);
			cnt++;
		end while (pick(sel) !== val && cnt < 300);
		if (pick(sel) !== val) begin
			bad_count++;
			$display("[FAIL] wait %0d expected %b seen %b", sel, val, pick(sel));
			end_sim();
		end
	endtask

	task automatic pulse_done();
		sfr_wr(8'h10, 8'h00, 1'b1);
		@(negedge ref_clk_in);
	endtask

	initial begin
		repeat (4) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		chk("core_rst", 1, core_rst_out);
		chk("latch", 16'h00FF, port_latch_out);
		chk("pullup", 1, pullup_en_out);
		chk("pin_oe", 1, rst_pin_oe_out);
		chk("pin", 0, rst_pin_out);
		chk("wdt_en", 0, wdt_en_out);
		@(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		repeat (6) @(posedge ref_clk_in);
		chk("held_low_vdd", 1, core_rst_out);
		vdd_ok_low_in <= 1'b1;
		vdd_ok_high_in <= 1'b1;
		wait_sig(0, 1'b0, n);
		chk("por_delay", 1, n >= POR_CYC);
		chk("pc_load", 1, pc_load_out);
		chk("wdt_en", 1, wdt_en_out);
		chk("wdt_div", 16'd12, wdt_div_out);
		chk("vector", 16'h0000, pc_vector_out);
		chk("clk_en", 16'h000F, clk_en_out);
		chk("pin_oe", 0, rst_pin_oe_out);
		sfr_rd(RSC_ADDR, rd);
		chk("cause", 16'h0006, rd & 8'h06);
		sfr_rd(MON_ADDR, rd);
		chk("monitor", 16'h00C0, rd & 8'hE0);
		sfr_rd(8'h10, rd);
		chk("unmapped", 16'h0000, rd);
		sfr_wr(PMC_ADDR, 8'hA9, 1'b0);
		sfr_rd(PMC_ADDR, rd);
		chk("power_mode_control", 16'h00A8, rd);
		pulse_done();
		chk("nap", 16'h0001, {clk_en_out.cpu, clk_en_out.periph});
		@(posedge ref_clk_in);
		irq_in <= 1'b1;
		wait_sig(3, 1'b1, n);
		@(posedge ref_clk_in);
		irq_in <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			sfr_wr(OSC_ADDR, (i == 0) ? 8'h20 : 8'h21, 1'b1);
			@(negedge ref_clk_in);
			chk("sleep", 16'h0001, clk_en_out);
			@(posedge ref_clk_in);
			cmp_low_in <= 1'b1;
			if (i == 0) begin
				repeat (6) @(posedge ref_clk_in);
				chk("no_cmp_wake", 16'h0001, clk_en_out);
				port_match_in <= 1'b1;
			end
			wait_sig(2, 1'b1, n);
			chk("wake_cpu", 0, clk_en_out.cpu);
			wait_sig(1, 1'b1, n);
			chk("stab", STAB_CYC + 1, n);
			chk("resume", 16'h000F, clk_en_out);
			chk("no_reset", 0, core_rst_out);
			@(posedge ref_clk_in);
			port_match_in <= 1'b0;
			cmp_low_in <= 1'b0;
		end
		sfr_wr(PMC_ADDR, 8'hFE, 1'b1);
		@(negedge ref_clk_in);
		chk("halt", 16'h0000, {clk_en_out.cpu, clk_en_out.periph, clk_en_out.hfosc});
		@(posedge ref_clk_in);
		port_match_in <= 1'b1;
		irq_in <= 1'b1;
		repeat (8) @(posedge ref_clk_in);
		chk("halt_stays", 16'h0000, {clk_en_out.cpu, core_rst_out});
		port_match_in <= 1'b0;
		irq_in <= 1'b0;
		ext_rst_b_in <= 1'b0;
		wait_sig(0, 1'b1, n);
		chk("force", 1, port_force_out);
		chk("latch", 16'h00FF, port_latch_out);
		repeat (2) @(posedge ref_clk_in);
		chk("ext_pin_oe", 0, rst_pin_oe_out);
		ext_rst_b_in <= 1'b1;
		wait_sig(0, 1'b0, n);
		chk("pc_load", 1, pc_load_out);
		sfr_rd(PMC_ADDR, rd);
		chk("power_mode_control_rst", 16'h0000, rd);
		sfr_rd(RSC_ADDR, rd);
		chk("cause_clr", 16'h0000, rd & 8'h02);
		sfr_wr(PMC_ADDR, 8'h02, 1'b1);
		clock_loss_in <= 1'b1;
		wait_sig(0, 1'b1, n);
		@(posedge ref_clk_in);
		clock_loss_in <= 1'b0;
		wait_sig(0, 1'b0, n);
		@(posedge ref_clk_in);
		flash_op_in <= 1'b1;
		@(posedge ref_clk_in);
		flash_op_in <= 1'b0;
		@(negedge ref_clk_in);
		chk("flash_err", 1, core_rst_out);
		wait_sig(0, 1'b0, n);
		sfr_wr(MON_ADDR, 8'hA0, 1'b0);
		@(posedge ref_clk_in);
		flash_op_in <= 1'b1;
		@(posedge ref_clk_in);
		flash_op_in <= 1'b0;
		repeat (3) @(negedge ref_clk_in);
		chk("flash_ok", 0, core_rst_out);
		@(posedge ref_clk_in);
		vdd_ok_high_in <= 1'b0;
		wait_sig(0, 1'b1, n);
		chk("mon_pin_oe", 1, rst_pin_oe_out);
		@(posedge ref_clk_in);
		vdd_ok_high_in <= 1'b1;
		wait_sig(0, 1'b0, n);
		chk("no_por_delay", 1, n < POR_CYC);
		sfr_rd(MON_ADDR, rd);
		chk("level_kept", 16'h00A0, rd & 8'hA0);
		@(posedge ref_clk_in);
		rst_b_in <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		wait_sig(0, 1'b0, n);
		sfr_rd(MON_ADDR, rd);
		chk("level_por", 16'h0080, rd & 8'hA0);
		sfr_wr(MON_ADDR, 8'h00, 1'b0);
		sfr_wr(RSC_ADDR, 8'h16, 1'b0);
		wait_sig(0, 1'b1, n);
		wait_sig(0, 1'b0, n);
		sfr_rd(MON_ADDR, rd);
		chk("mon_off_kept", 16'h0000, rd & 8'h80);
		sfr_wr(MON_ADDR, 8'h80, 1'b0);
		sfr_wr(RSC_ADDR, 8'h06, 1'b0);
		repeat (4) @(negedge ref_clk_in);
		chk("mon_source_on", 0, core_rst_out);
		sfr_rd(MON_ADDR, rd);
		chk("mon_on", 16'h00C0, rd & 8'hC0);
		end_sim();
	end
endmodule
`default_nettype wire

// >>> verilog/pmrc_sync.sv
// Two-stage synchroniser for asynchronous level inputs.
`timescale 1ns/100ps
`default_nettype none
module pmrc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// Each lane owns its flip-flops so that no vector has more than one writing process.
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_lane
			logic meta_q;
			logic sync_q;
			always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					meta_q <= RST_VAL[i];
					sync_q <= RST_VAL[i];
				end else begin
					meta_q <= async_in[i];
					sync_q <= meta_q;
				end
			end
			assign sync_out[i] = sync_q;
		end
	endgenerate
endmodule
`default_nettype wire

// >>> verilog/pmrc_top.sv
// Power mode and reset sequencing controller of the microcontroller.
//
// Overview of operation
// - Writing the halt select bit enters deep halt when the writing instruction completes.
// - Deep halt stops internal oscillator, CPU and digital peripherals; external oscillator untouched.
// - Deep halt ends only by reset, followed by the normal reset sequence.
// - Enabled clock-loss detector resets out of deep halt; software disables it first.
// - Writing the sleep select bit stops CPU and fast oscillator after the instruction.
// - In sleep only the port-match function keeps running.
// - Sleep ends on port match, enabled comparator low, or any reset.
// - Non-reset wake resumes at the next instruction and flags the wake interrupt.
// - Upper six power control bits are plain read/write scratch flags, reset zero.
// - Halt and nap select bits always read back as zero.
// - Nap select gates only the CPU clock, peripherals stay clocked.
// - Reset halts the CPU, resets registers, forces ports, disables timers.
// - Reset loads port latches with all ones, pull-ups stay enabled.
// - Power-up and supply-monitor resets drive the reset pin low until exit.
// - Reset exit loads the vector, enables watchdog at clock divided by twelve.
// - Power-up waits for supply above threshold, then an extra delay.
// - Power-up reset sets the power-up flag; other resets clear it.
// - Supply monitor enabled by power-up; other resets leave its state alone.
// - Supply below threshold holds reset; recovery releases with no extra delay.
// - Flash write or erase without monitor enabled at high level resets.
// - High threshold may hold reset until power-up, which restores low threshold.
// - Monitor level bit zero picks the low threshold, one the high.
`timescale 1ns/100ps
`default_nettype none
module pmrc_top import pmrc_pkg::*; #(
	parameter int POR_DELAY_CYC = POR_DELAY_CYC_DEF,
	parameter int OSC_STAB_CYC = OSC_STAB_CYC_DEF
) (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic ext_rst_b_in,
	input wire logic vdd_ok_low_in,
	input wire logic vdd_ok_high_in,
	input wire logic port_match_in,
	input wire logic cmp_low_in,
	input wire logic clock_loss_in,
	input wire pmrc_sfr_s sfr_in,
	input wire logic instr_done_in,
	input wire logic irq_in,
	input wire logic flash_op_in,
	output logic [7:0] sfr_rdata_out,
	output pmrc_clk_s clk_en_out,
	output logic core_rst_out,
	output logic port_force_out,
	output logic [7:0] port_latch_out,
	output logic pullup_en_out,
	output logic rst_pin_out,
	output logic rst_pin_oe_out,
	output logic wdt_en_out,
	output logic [3:0] wdt_div_out,
	output logic pc_load_out,
	output logic [15:0] pc_vector_out,
	output logic wake_irq_out
);
	localparam logic [CNT_W-1:0] POR_CNT = CNT_W'(POR_DELAY_CYC);
	localparam logic [CNT_W-1:0] OSC_CNT = CNT_W'(OSC_STAB_CYC);

	pmrc_state_e state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic cnt_inc;
	logic [5:0] scratch_q;
	logic halt_pend_q, nap_pend_q, sleep_pend_q;
	logic mon_en_q, mon_lvl_q, mon_src_q, mcd_en_q, cmpw_en_q;
	logic por_flag_q, from_por_q, pin_drive_q;
	pmrc_clk_s clk_en_q, clk_en_d;
	logic [7:0] rdata_q, rdata_w;
	logic core_rst_q, port_force_q, pullup_q, rst_pin_q, rst_pin_oe_q;
	logic [7:0] port_latch_q;
	logic wdt_en_q, pc_load_q, wake_irq_q;
	logic [3:0] wdt_div_q;
	logic [15:0] pc_vector_q;
	logic [SY_W-1:0] sync_w;

	// Pin-side levels are synchronised before any decision looks at them.
	pmrc_sync #(.WIDTH(SY_W), .RST_VAL(SYNC_RST_VAL)) u_sync (
		.ref_clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.async_in({clock_loss_in, cmp_low_in, port_match_in, vdd_ok_high_in, vdd_ok_low_in,
			ext_rst_b_in}),
		.sync_out(sync_w)
	);

	wire ext_rst_w = ~sync_w[SY_EXT];
	wire vdd_low_ok_w = sync_w[SY_VLO];
	wire vdd_high_ok_w = sync_w[SY_VHI];
	wire port_match_w = sync_w[SY_PM];
	wire cmp_low_w = sync_w[SY_CMP];
	wire clk_loss_w = sync_w[SY_MCD];

	// Register port decode; the CPU only issues accesses while it runs.
	wire run_w = (state_q == ST_RUN);
	wire wr_ok_w = sfr_in.wr & run_w;
	wire pmc_wr_w = wr_ok_w & (sfr_in.addr == PMC_ADDR);
	wire osc_wr_w = wr_ok_w & (sfr_in.addr == OSC_ADDR);
	wire mon_wr_w = wr_ok_w & (sfr_in.addr == MON_ADDR);
	wire rsc_wr_w = wr_ok_w & (sfr_in.addr == RSC_ADDR);

	// A mode request written by the same instruction that completes is honoured at once.
	wire halt_req_w = halt_pend_q | (pmc_wr_w & sfr_in.wdata[PMC_HALT_BIT]);
	wire nap_req_w = nap_pend_q | (pmc_wr_w & sfr_in.wdata[PMC_NAP_BIT]);
	wire sleep_req_w = sleep_pend_q | (osc_wr_w & sfr_in.wdata[OSC_SLEEP_BIT]);

	// Threshold comparator chosen by the level bit.
	wire vdd_ok_w = mon_lvl_q ? vdd_high_ok_w : vdd_low_ok_w;

	// Reset sources.
	wire mon_rst_w = mon_en_q & mon_src_q & ~vdd_ok_w;
	wire flash_err_w = flash_op_in & run_w & ~(mon_en_q & mon_lvl_q);
	wire mcd_rst_w = mcd_en_q & clk_loss_w;
	wire sw_rst_w = rsc_wr_w & sfr_in.wdata[RSC_SWR_BIT];
	wire hold_w = ext_rst_w | mon_rst_w;
	wire any_rst_w = hold_w | flash_err_w | mcd_rst_w | sw_rst_w;

	// Power-up release needs the supply above threshold and the full delay behind it.
	wire por_ready_w = vdd_low_ok_w & (cnt_q == POR_CNT);
	wire rel_w = ~hold_w & (~from_por_q | por_ready_w);
	wire cnt_clr_w = (state_q == ST_RESET) & (hold_w | ~vdd_low_ok_w);
	wire wake_w = port_match_w | (cmpw_en_q & cmp_low_w);
	wire enter_rst_w = (state_d == ST_RESET) & (state_q != ST_RESET);
	wire exit_rst_w = (state_q == ST_RESET) & (state_d != ST_RESET);

	always_comb begin
		state_d = state_q;
		cnt_inc = 1'b0;
		case (state_q)
			ST_RESET: begin
				cnt_inc = from_por_q & (cnt_q != POR_CNT);
				if (rel_w) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (instr_done_in & halt_req_w) begin
					state_d = ST_HALT;
				end else if (instr_done_in & sleep_req_w) begin
					state_d = ST_SLEEP;
				end else if (instr_done_in & nap_req_w) begin
					state_d = ST_NAP;
				end
			end
			ST_NAP: begin
				if (irq_in) begin
					state_d = ST_RUN;
				end
			end
			ST_HALT: begin
				state_d = ST_HALT;
			end
			ST_SLEEP: begin
				if (wake_w) begin
					state_d = ST_WAKE;
				end
			end
			ST_WAKE: begin
				cnt_inc = (cnt_q != OSC_CNT);
				if (cnt_q == OSC_CNT) begin
					state_d = ST_RUN;
				end
			end
			default: begin
				state_d = ST_RESET;
			end
		endcase
		if (any_rst_w) begin
			state_d = ST_RESET;
		end
	end

	always_comb begin
		if ((state_d != state_q) || cnt_clr_w) begin
			cnt_d = '0;
		end else if (cnt_inc) begin
			cnt_d = cnt_q + CNT_W'(1);
		end else begin
			cnt_d = cnt_q;
		end
	end

	// Clock gating per mode; the external oscillator is not ours to touch.
	always_comb begin
		clk_en_d.cpu = (state_d == ST_RUN);
		clk_en_d.periph = (state_d == ST_RUN) | (state_d == ST_NAP);
		clk_en_d.hfosc = ~((state_d == ST_HALT) | (state_d == ST_SLEEP));
		clk_en_d.port_match = ~((state_d == ST_HALT) | (state_d == ST_RESET));
	end

	wire pin_drive_d = (state_d == ST_RESET) & (pin_drive_q | mon_rst_w);

	// Readback; mode select bits and the sleep bit never read back as set.
	always_comb begin
		rdata_w = RDATA_ZERO;
		if (sfr_in.addr == PMC_ADDR) begin
			rdata_w[PMC_SCR_MSB:PMC_SCR_LSB] = scratch_q;
		end else if (sfr_in.addr == OSC_ADDR) begin
			rdata_w[OSC_CMPW_BIT] = cmpw_en_q;
		end else if (sfr_in.addr == MON_ADDR) begin
			rdata_w[MON_EN_BIT] = mon_en_q;
			rdata_w[MON_STAT_BIT] = vdd_ok_w;
			rdata_w[MON_LVL_BIT] = mon_lvl_q;
		end else if (sfr_in.addr == RSC_ADDR) begin
			rdata_w[RSC_SRC_BIT] = por_flag_q;
			rdata_w[RSC_MCD_BIT] = mcd_en_q;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q <= ST_RESET;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// Only power-up touches the monitor settings; every other reset leaves them.
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mon_en_q <= MON_EN_RST;
			mon_lvl_q <= MON_LVL_RST;
			mon_src_q <= MON_SRC_RST;
		end else if (mon_wr_w) begin
			mon_en_q <= sfr_in.wdata[MON_EN_BIT];
			mon_lvl_q <= sfr_in.wdata[MON_LVL_BIT];
		end else if (rsc_wr_w) begin
			mon_src_q <= sfr_in.wdata[RSC_SRC_BIT];
		end
	end

	// Ordinary control registers return to their reset values on any reset.
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			scratch_q <= SCR_RST;
			cmpw_en_q <= CMPW_RST;
			mcd_en_q <= MCD_EN_RST;
		end else if (state_q == ST_RESET) begin
			scratch_q <= SCR_RST;
			cmpw_en_q <= CMPW_RST;
			mcd_en_q <= MCD_EN_RST;
		end else begin
			scratch_q <= pmc_wr_w ? sfr_in.wdata[PMC_SCR_MSB:PMC_SCR_LSB] : scratch_q;
			cmpw_en_q <= osc_wr_w ? sfr_in.wdata[OSC_CMPW_BIT] : cmpw_en_q;
			mcd_en_q <= rsc_wr_w ? sfr_in.wdata[RSC_MCD_BIT] : mcd_en_q;
		end
	end

	// Requests wait for the writing instruction to complete; leaving run clears them.
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			halt_pend_q <= 1'b0;
			nap_pend_q <= 1'b0;
			sleep_pend_q <= 1'b0;
		end else begin
			halt_pend_q <= halt_req_w & (state_d == ST_RUN);
			nap_pend_q <= nap_req_w & (state_d == ST_RUN);
			sleep_pend_q <= sleep_req_w & (state_d == ST_RUN);
		end
	end

	// Reset cause tracking.
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			por_flag_q <= 1'b1;
			from_por_q <= 1'b1;
			pin_drive_q <= 1'b1;
		end else begin
			por_flag_q <= enter_rst_w ? 1'b0 : por_flag_q;
			from_por_q <= exit_rst_w ? 1'b0 : from_por_q;
			pin_drive_q <= pin_drive_d;
		end
	end

	// Registered outputs; mode and reset outputs decoded from the next state, readback data latched on reads.
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			clk_en_q <= '0;
			core_rst_q <= 1'b1;
			port_force_q <= 1'b1;
			port_latch_q <= PORT_LATCH_RST;
			pullup_q <= 1'b1;
			rst_pin_q <= 1'b0;
			rst_pin_oe_q <= 1'b1;
			wdt_en_q <= 1'b0;
			wdt_div_q <= WDT_CLK_DIV;
			pc_load_q <= 1'b0;
			pc_vector_q <= RESET_VECTOR;
			wake_irq_q <= 1'b0;
			rdata_q <= RDATA_ZERO;
		end else begin
			clk_en_q <= clk_en_d;
			core_rst_q <= (state_d == ST_RESET);
			port_force_q <= (state_d == ST_RESET);
			port_latch_q <= (state_d == ST_RESET) ? PORT_LATCH_RST : port_latch_q;
			pullup_q <= 1'b1;
			rst_pin_q <= 1'b0;
			rst_pin_oe_q <= pin_drive_d;
			wdt_en_q <= exit_rst_w | (wdt_en_q & (state_d != ST_RESET));
			wdt_div_q <= exit_rst_w ? WDT_CLK_DIV : wdt_div_q;
			pc_load_q <= exit_rst_w;
			pc_vector_q <= exit_rst_w ? RESET_VECTOR : pc_vector_q;
			wake_irq_q <= (state_q == ST_WAKE) & (state_d == ST_RUN);
			rdata_q <= sfr_in.rd ? rdata_w : rdata_q;
		end
	end

	assign clk_en_out = clk_en_q;
	assign core_rst_out = core_rst_q;
	assign port_force_out = port_force_q;
	assign port_latch_out = port_latch_q;
	assign pullup_en_out = pullup_q;
	assign rst_pin_out = rst_pin_q;
	assign rst_pin_oe_out = rst_pin_oe_q;
	assign wdt_en_out = wdt_en_q;
	assign wdt_div_out = wdt_div_q;
	assign pc_load_out = pc_load_q;
	assign pc_vector_out = pc_vector_q;
	assign wake_irq_out = wake_irq_q;
	assign sfr_rdata_out = rdata_q;

	// Checks.
	a_halt_entry: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		(run_w && instr_done_in && halt_req_w && !any_rst_w) |=> (state_q == ST_HALT))
		else $error("halt not entered after completing instruction");

	a_halt_clocks: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		(state_q == ST_HALT) |-> (clk_en_out == '0))
		else $error("clock still enabled in deep halt");

	a_halt_stays: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		(state_q == ST_HALT && !any_rst_w) |=> (state_q == ST_HALT))
		else $error("deep halt left without reset");

	a_mcd_reset: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		(state_q == ST_HALT && mcd_en_q && clk_loss_w) |=> (state_q == ST_RESET && core_rst_out))
		else $error("clock loss did not reset out of halt");

	a_sleep_pm: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		(state_q == ST_SLEEP) |-> (clk_en_out.port_match && !clk_en_out.periph && !clk_en_out.cpu))
		else $error("sleep clocks wrong");

	a_sleep_wake: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		(state_q == ST_SLEEP && port_match_w && !any_rst_w) |=> (state_q == ST_WAKE))
		else $error("port match did not wake from sleep");

	a_wake_cpu: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		($rose(state_q == ST_WAKE)) |-> (!clk_en_out.cpu && clk_en_out.hfosc)[*8])
		else $error("cpu clocked before oscillator settled");

	a_readback_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		(sfr_in.rd && sfr_in.addr == PMC_ADDR) |=> (sfr_rdata_out[1:0] == 2'b00))
		else $error("mode select bits read back set");

	a_pin_drive: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		(mon_rst_w) |=> (rst_pin_oe_out && !rst_pin_out && core_rst_out))
		else $error("reset pin not driven on supply reset");

	a_por_flag: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		(run_w && any_rst_w) |=> ##1 (por_flag_q == 1'b0))
		else $error("power-up flag survived another reset");

	a_flash_err: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		(flash_op_in && run_w && !mon_lvl_q) |=> (state_q == ST_RESET && port_force_out))
		else $error("flash error did not reset");

	a_exit_vector: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
		$fell(core_rst_out) |-> (pc_load_out && wdt_en_out && wdt_div_out == WDT_CLK_DIV))
		else $error("reset exit sequence incomplete");
endmodule
`default_nettype wire
